/* File: core/center_aligned_pwm_timer.v */
// Center-aligned PWM timer: APB register slave, main counter, channel array.
// Assumes synchronous pin inputs, a single clock, and ce freezing all state.
`timescale 1ns/100ps
`include "center_aligned_pwm_map.vh"
module center_aligned_pwm_timer (
  // Clock, reset, freeze
  input  wire                  pclk,
  input  wire                  presetn,
  input  wire                  ce,
  // APB slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [7:0]            paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  // Channel pins
  input  wire [`CENTER_ALIGNED_PWM_NCH-1:0]  cap_in,
  output wire [`CENTER_ALIGNED_PWM_NCH-1:0]  ch_out,
  output wire [`CENTER_ALIGNED_PWM_NCH-1:0]  ch_oe,
  // Interrupt requests
  output reg                   ovf_irq,
  output wire [`CENTER_ALIGNED_PWM_NCH-1:0]  ch_irq
);

  // Channel n register group hit, used by the write and read paths
  function chan_hit;
    input [7:0] a;
    input integer n;
    begin
      chan_hit = (a[7:4] == `CENTER_ALIGNED_PWM_CH_BASE + n[3:0]) && (a[1:0] == 2'h0) && (a[3:2] != 2'h3);
    end
  endfunction

  // Main control and counter state
  reg  [6:0]  sc;
  reg  [15:0] cnt;
  reg         up;
  reg  [6:0]  presc;
  reg  [15:0] mod;
  reg  [15:0] mod_buf;
  reg         mod_hw;
  reg         mod_lw;
  reg  [31:0] next_rdata;
  reg         next_err;
  integer     i;

  wire                     ovf_flag;
  wire [8*`CENTER_ALIGNED_PWM_NCH-1:0]   chsc_flat;
  wire [16*`CENTER_ALIGNED_PWM_NCH-1:0]  cv_flat;
  wire [`CENTER_ALIGNED_PWM_NCH-1:0]     hit_flat;

  // Completed transfers: taken at the edge where pready is seen high
  wire acc = ce & psel & penable & pready;
  wire wr  = acc & pwrite;
  wire rd  = acc & ~pwrite;

  wire       cas       = sc[`CENTER_ALIGNED_PWM_CAS_BIT];
  wire [1:0] clks      = sc[`CENTER_ALIGNED_PWM_CLKS_MSB:`CENTER_ALIGNED_PWM_CLKS_LSB];
  wire       clks_off  = (clks == `CENTER_ALIGNED_PWM_CLKS_OFF);
  wire [6:0] ps_mask   = (7'h01 << sc[`CENTER_ALIGNED_PWM_PS_MSB:`CENTER_ALIGNED_PWM_PS_LSB]) - 7'h01;
  wire       tick      = ce & ~clks_off & (presc == ps_mask);
  wire       free      = (mod == `CENTER_ALIGNED_PWM_MOD_RST);
  wire [15:0] top      = free ? `CENTER_ALIGNED_PWM_FREE_TOP : mod;

  wire sc_wr   = wr & (paddr == `CENTER_ALIGNED_PWM_SC_ADDR);
  wire cnt_wr  = wr & ((paddr == `CENTER_ALIGNED_PWM_CNTH_ADDR) | (paddr == `CENTER_ALIGNED_PWM_CNTL_ADDR));
  wire modh_wr = wr & (paddr == `CENTER_ALIGNED_PWM_MODH_ADDR);
  wire modl_wr = wr & (paddr == `CENTER_ALIGNED_PWM_MODL_ADDR);

  // Overflow at the end of the terminal count; in up/down mode only on the way up
  wire ovf_evt = tick & (cnt == top) & (~cas | up);
  // Buffered loads happen on the step into the terminal count
  wire load_pt = tick & up & (cnt == top - 16'h0001);

  wire mod_both = (modh_wr & mod_lw) | (modl_wr & mod_hw);
  wire [15:0] mod_new = modh_wr ? {pwdata[7:0], mod_buf[7:0]} : {mod_buf[15:8], pwdata[7:0]};

  // Main control register; cleared by any reset so clocking stops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sc <= `CENTER_ALIGNED_PWM_SC_RST;
    else if (ce && sc_wr)
      sc <= pwdata[6:0];
  end

  // Prescaler; a counter write restarts it together with the count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      presc <= 7'h00;
    else if (ce) begin
      if (cnt_wr || clks_off || tick)
        presc <= 7'h00;
      else
        presc <= presc + 7'h01;
    end
  end

  // Main counter: plain up count or up/down between zero and modulo
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      up  <= 1'b1;
    end else if (ce) begin
      if (cnt_wr) begin
        cnt <= 16'h0000;
        up  <= 1'b1;
      end else if (tick) begin
        if (cas) begin
          // Modulo zero would run to 0xFFFF before turning; software avoids it
          if (up) begin
            if (cnt >= top) begin
              up  <= 1'b0;
              cnt <= cnt - 16'h0001;
            end else
              cnt <= cnt + 16'h0001;
          end else begin
            if (cnt == 16'h0000) begin
              up  <= 1'b1;
              cnt <= 16'h0001;
            end else
              cnt <= cnt - 16'h0001;
          end
        end else begin
          up  <= 1'b1;
          cnt <= (cnt == top) ? 16'h0000 : cnt + 16'h0001;
        end
      end
    end
  end

  // Modulo holding buffer; the active value only changes as a whole word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod     <= `CENTER_ALIGNED_PWM_MOD_RST;
      mod_buf <= `CENTER_ALIGNED_PWM_MOD_RST;
      mod_hw  <= 1'b0;
      mod_lw  <= 1'b0;
    end else if (ce) begin
      if (sc_wr) begin
        mod_hw <= 1'b0;
        mod_lw <= 1'b0;
      end else if (mod_both && clks_off) begin
        mod    <= mod_new;
        mod_hw <= 1'b0;
        mod_lw <= 1'b0;
      end else if (modh_wr) begin
        mod_buf[15:8] <= pwdata[7:0];
        mod_hw        <= 1'b1;
      end else if (modl_wr) begin
        mod_buf[7:0] <= pwdata[7:0];
        mod_lw       <= 1'b1;
      end else if (mod_hw && mod_lw && load_pt) begin
        mod    <= mod_buf;
        mod_hw <= 1'b0;
        mod_lw <= 1'b0;
      end
    end
  end

  // Overflow flag with its two-step clear
  center_aligned_pwm_flag u_ovf_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .set     (ovf_evt),
    .rd      (rd & (paddr == `CENTER_ALIGNED_PWM_SC_ADDR)),
    .wr      (sc_wr),
    .wbit    (pwdata[`CENTER_ALIGNED_PWM_FLAG_BIT]),
    .flag    (ovf_flag)
  );

  // Registered request; lags the flag by one cycle to keep the output a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ovf_irq <= 1'b0;
    else if (ce)
      ovf_irq <= ovf_flag & sc[`CENTER_ALIGNED_PWM_IE_BIT];
  end

  // Channel array
  genvar g;
  generate
    for (g = 0; g < `CENTER_ALIGNED_PWM_NCH; g = g + 1) begin : gch
      reg  [6:2]  ctl;
      reg  [15:0] cv;
      reg  [15:0] cv_buf;
      reg         hw;
      reg         lw;
      reg         irq;
      wire        flag;
      wire        cap_evt;
      wire        match_evt;
      wire        pin_out;
      wire        pin_oe;

      wire hit   = chan_hit(paddr, g);
      wire csc_w = wr & hit & (paddr[3:2] == `CENTER_ALIGNED_PWM_CH_SC);
      wire vh_w  = wr & hit & (paddr[3:2] == `CENTER_ALIGNED_PWM_CH_VH);
      wire vl_w  = wr & hit & (paddr[3:2] == `CENTER_ALIGNED_PWM_CH_VL);
      wire both  = (vh_w & lw) | (vl_w & hw);
      wire [15:0] cv_new = vh_w ? {pwdata[7:0], cv_buf[7:0]} : {cv_buf[15:8], pwdata[7:0]};

      // Control, value buffer and coherent load; a capture overrides the value
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctl    <= `CENTER_ALIGNED_PWM_CTL_RST;
          cv     <= `CENTER_ALIGNED_PWM_CV_RST;
          cv_buf <= `CENTER_ALIGNED_PWM_CV_RST;
          hw     <= 1'b0;
          lw     <= 1'b0;
        end else if (ce) begin
          if (csc_w) begin
            ctl <= pwdata[6:2];
            hw  <= 1'b0;
            lw  <= 1'b0;
          end else if (both && clks_off) begin
            cv <= cv_new;
            hw <= 1'b0;
            lw <= 1'b0;
          end else if (vh_w) begin
            cv_buf[15:8] <= pwdata[7:0];
            hw           <= 1'b1;
          end else if (vl_w) begin
            cv_buf[7:0] <= pwdata[7:0];
            lw          <= 1'b1;
          end else if (hw && lw && load_pt) begin
            cv <= cv_buf;
            hw <= 1'b0;
            lw <= 1'b0;
          end
          if (cap_evt)
            cv <= cnt;
        end
      end

      center_aligned_pwm_chan u_chan (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .tick      (tick),
        .cnt       (cnt),
        .up        (up),
        .cas       (cas),
        .ovf_evt   (ovf_evt),
        .ms        (ctl[`CENTER_ALIGNED_PWM_MS_MSB:`CENTER_ALIGNED_PWM_MS_LSB]),
        .els       (ctl[`CENTER_ALIGNED_PWM_ELS_MSB:`CENTER_ALIGNED_PWM_ELS_LSB]),
        .cv        (cv),
        .cap_in    (cap_in[g]),
        .pin_out   (pin_out),
        .pin_oe    (pin_oe),
        .cap_evt   (cap_evt),
        .match_evt (match_evt)
      );

      center_aligned_pwm_flag u_flag (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .set     (cap_evt | match_evt),
        .rd      (rd & hit & (paddr[3:2] == `CENTER_ALIGNED_PWM_CH_SC)),
        .wr      (csc_w),
        .wbit    (pwdata[`CENTER_ALIGNED_PWM_FLAG_BIT]),
        .flag    (flag)
      );

      // Level request while flag and enable both stand
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          irq <= 1'b0;
        else if (ce)
          irq <= flag & ctl[`CENTER_ALIGNED_PWM_IE_BIT];
      end

      assign ch_irq[g]            = irq;
      assign ch_out[g]            = pin_out;
      assign ch_oe[g]             = pin_oe;
      assign chsc_flat[8*g +: 8]  = {flag, ctl, 2'b00};
      assign cv_flat[16*g +: 16]  = cv;
      assign hit_flat[g]          = hit;
    end
  endgenerate

  // Read data and error for the addressed register, looked up in the setup cycle
  always @* begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    case (paddr)
      `CENTER_ALIGNED_PWM_SC_ADDR:   next_rdata[7:0] = {ovf_flag, sc};
      `CENTER_ALIGNED_PWM_CNTH_ADDR: next_rdata[7:0] = cnt[15:8];
      `CENTER_ALIGNED_PWM_CNTL_ADDR: next_rdata[7:0] = cnt[7:0];
      `CENTER_ALIGNED_PWM_MODH_ADDR: next_rdata[7:0] = mod[15:8];
      `CENTER_ALIGNED_PWM_MODL_ADDR: next_rdata[7:0] = mod[7:0];
      default: begin
        next_err = ~|hit_flat;
        for (i = 0; i < `CENTER_ALIGNED_PWM_NCH; i = i + 1) begin
          if (hit_flat[i]) begin
            case (paddr[3:2])
              `CENTER_ALIGNED_PWM_CH_SC: next_rdata[7:0] = chsc_flat[8*i +: 8];
              `CENTER_ALIGNED_PWM_CH_VH: next_rdata[7:0] = cv_flat[16*i+8 +: 8];
              default:     next_rdata[7:0] = cv_flat[16*i +: 8];
            endcase
          end
        end
      end
    endcase
  end

  // APB answer: one wait-free access cycle after every setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel & ~penable & ~pready;
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h00000000 : next_rdata;
        pslverr <= next_err;
      end
    end
  end

endmodule

/* File: core/center_aligned_pwm_map.vh */
// Constants for the center-aligned PWM timer: offsets, bit fields, resets.
// Assumes an APB slave with byte-wide registers in the low 8 bits of each word.
`ifndef CENTER_ALIGNED_PWM_MAP_VH
`define CENTER_ALIGNED_PWM_MAP_VH

// Channel count
`define CENTER_ALIGNED_PWM_NCH        2

// Main register byte addresses
`define CENTER_ALIGNED_PWM_SC_ADDR    8'h00
`define CENTER_ALIGNED_PWM_CNTH_ADDR  8'h04
`define CENTER_ALIGNED_PWM_CNTL_ADDR  8'h08
`define CENTER_ALIGNED_PWM_MODH_ADDR  8'h0C
`define CENTER_ALIGNED_PWM_MODL_ADDR  8'h10

// Channel n occupies addr[7:4] = base + n, register chosen by addr[3:2]
`define CENTER_ALIGNED_PWM_CH_BASE    4'h2
`define CENTER_ALIGNED_PWM_CH_SC      2'h0
`define CENTER_ALIGNED_PWM_CH_VH      2'h1
`define CENTER_ALIGNED_PWM_CH_VL      2'h2

// Shared status/control bit positions
`define CENTER_ALIGNED_PWM_FLAG_BIT   7
`define CENTER_ALIGNED_PWM_IE_BIT     6
// Main status/control fields
`define CENTER_ALIGNED_PWM_CAS_BIT    5
`define CENTER_ALIGNED_PWM_CLKS_MSB   4
`define CENTER_ALIGNED_PWM_CLKS_LSB   3
`define CENTER_ALIGNED_PWM_PS_MSB     2
`define CENTER_ALIGNED_PWM_PS_LSB     0
// Channel status/control fields
`define CENTER_ALIGNED_PWM_MS_MSB     5
`define CENTER_ALIGNED_PWM_MS_LSB     4
`define CENTER_ALIGNED_PWM_ELS_MSB    3
`define CENTER_ALIGNED_PWM_ELS_LSB    2
`define CENTER_ALIGNED_PWM_ELSA_BIT   2

// Reset values
`define CENTER_ALIGNED_PWM_SC_RST     7'h00
`define CENTER_ALIGNED_PWM_CTL_RST    5'h00
`define CENTER_ALIGNED_PWM_MOD_RST    16'h0000
`define CENTER_ALIGNED_PWM_CV_RST     16'h0000

// Encodings
`define CENTER_ALIGNED_PWM_FREE_TOP   16'hFFFF
`define CENTER_ALIGNED_PWM_CLKS_OFF   2'h0
`define CENTER_ALIGNED_PWM_MS_CAP     2'h0
`define CENTER_ALIGNED_PWM_MS_CMP     2'h1
`define CENTER_ALIGNED_PWM_ELS_OFF    2'h0
`define CENTER_ALIGNED_PWM_ELS_RISE   2'h1
`define CENTER_ALIGNED_PWM_ELS_FALL   2'h2
`define CENTER_ALIGNED_PWM_ELS_BOTH   2'h3
`define CENTER_ALIGNED_PWM_OC_TOGGLE  2'h1
`define CENTER_ALIGNED_PWM_OC_CLEAR   2'h2
`define CENTER_ALIGNED_PWM_OC_SET     2'h3

`endif

/* File: core/center_aligned_pwm_flag.v */
// Event flag with read-then-write-zero clearing.
// Assumes rd and wr are single-cycle pulses on completed bus transfers.
`timescale 1ns/100ps
module center_aligned_pwm_flag (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  // Event and bus strobes
  input  wire set,
  input  wire rd,
  input  wire wr,
  input  wire wbit,
  // State
  output reg  flag
);

  reg armed;

  // New event re-arms nothing and wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag  <= 1'b0;
      armed <= 1'b0;
    end else if (ce) begin
      if (set) begin
        flag  <= 1'b1;
        armed <= 1'b0;
      end else begin
        if (rd && flag)
          armed <= 1'b1;
        if (wr) begin
          armed <= 1'b0;
          if (!wbit && armed)
            flag <= 1'b0;
        end
      end
    end
  end

endmodule

/* File: core/center_aligned_pwm_chan.v */
// One timer channel: capture edge detect, compare match and pin shaping.
// Assumes cnt, up and tick come from the shared main counter.
`timescale 1ns/100ps
`include "center_aligned_pwm_map.vh"
module center_aligned_pwm_chan (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  // Counter state
  input  wire        tick,
  input  wire [15:0] cnt,
  input  wire        up,
  input  wire        cas,
  input  wire        ovf_evt,
  // Channel setup
  input  wire [1:0]  ms,
  input  wire [1:0]  els,
  input  wire [15:0] cv,
  // Pin side
  input  wire        cap_in,
  output reg         pin_out,
  output reg         pin_oe,
  // Events
  output wire        cap_evt,
  output wire        match_evt
);

  reg cap_prev;

  wire capmode = ~cas & (ms == `CENTER_ALIGNED_PWM_MS_CAP);
  wire rise    = cap_in & ~cap_prev;
  wire fall    = ~cap_in & cap_prev;
  wire els_a   = els[0];
  // In center-aligned mode a zero or negative value never yields a pulse
  wire cv_dead = (cv == `CENTER_ALIGNED_PWM_CV_RST) | cv[15];

  // Selected edge in capture mode
  assign cap_evt = ce & capmode &
                   (((els == `CENTER_ALIGNED_PWM_ELS_RISE) & rise) |
                    ((els == `CENTER_ALIGNED_PWM_ELS_FALL) & fall) |
                    ((els == `CENTER_ALIGNED_PWM_ELS_BOTH) & (rise | fall)));
  // Any counter match outside capture mode
  assign match_evt = tick & ~capmode & (cnt == cv);

  // Pin shaping per mode; pin released in capture mode or with both select bits clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_prev <= 1'b0;
      pin_out  <= 1'b0;
      pin_oe   <= 1'b0;
    end else if (ce) begin
      cap_prev <= cap_in;
      pin_oe   <= ~capmode & (els != `CENTER_ALIGNED_PWM_ELS_OFF);
      if (cas) begin
        if (cv_dead)
          pin_out <= els_a;
        else if (match_evt)
          pin_out <= up ? els_a : ~els_a;
        else if (tick && cnt == 16'h0000)
          pin_out <= ~els_a;
      end else if (ms[1]) begin
        if (match_evt)
          pin_out <= els_a;
        else if (ovf_evt)
          pin_out <= ~els_a;
      end else if (ms == `CENTER_ALIGNED_PWM_MS_CMP && match_evt) begin
        case (els)
          `CENTER_ALIGNED_PWM_OC_TOGGLE: pin_out <= ~pin_out;
          `CENTER_ALIGNED_PWM_OC_CLEAR:  pin_out <= 1'b0;
          `CENTER_ALIGNED_PWM_OC_SET:    pin_out <= 1'b1;
          default:         pin_out <= pin_out;
        endcase
      end
    end
  end

endmodule

/* File: tb/center_aligned_pwm_timer_properties.sv */
// Checker for the timer's APB answer, reset state, pin enables and irq levels.
// Assumes ce stays high and channel 0 control sits at byte address 0x20.
`timescale 1ns/100ps
module center_aligned_pwm_timer_properties (
  // Clock and reset
  input logic        pclk,
  input logic        presetn,
  input logic        ce,
  // APB
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Pins and requests
  input logic [1:0]  ch_oe,
  input logic        ovf_irq,
  input logic [1:0]  ch_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed transfers as single names, so $past sees one signal
  wire wr_done = psel & penable & pwrite & pready;
  wire sc_wr   = wr_done & (paddr == 8'h00);
  wire rd_ok   = psel & penable & !pwrite & pready & prdata[7] & prdata[6];
  wire rd_sc   = rd_ok & (paddr == 8'h00);
  wire rd_ch0  = rd_ok & (paddr == 8'h20);

  AST_SETUP_ANSWER: assert property (psel && !penable && ce |=> pready) else $error("no answer after setup");
  AST_READY_ONE: assert property (pready && ce |=> !pready) else $error("pready longer than one cycle");
  AST_READY_CAUSE: assert property (pready |-> $past(psel) && penable) else $error("pready without a request");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");
  AST_ERR_TIMING: assert property ($rose(pslverr) |-> pready) else $error("error outside access cycle");
  AST_RESET_QUIET:
    assert property ($rose(presetn) |-> ch_oe == 2'h0 && !ovf_irq && ch_irq == 2'h0) else $error("outputs not idle");
  AST_OE_BY_WRITE:
    assert property (!$stable(ch_oe) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
      else $error("pin enable moved without a write");
  AST_OVF_LEVEL: assert property (rd_sc |=> ovf_irq) else $error("overflow request low");
  AST_CH_LEVEL: assert property (rd_ch0 |=> ch_irq[0]) else $error("channel request low");
  AST_OVF_CLEAR:
    assert property ($fell(ovf_irq) |-> $past(sc_wr) || $past(sc_wr, 2) || $past(sc_wr, 3))
      else $error("overflow request fell without a write");
endmodule

bind center_aligned_pwm_timer center_aligned_pwm_timer_properties u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_oe(ch_oe),
  .ovf_irq(ovf_irq), .ch_irq(ch_irq)
);

/* File: tb/center_aligned_pwm_load_model.sv */
// External load on one channel pad: resolves the pad level and times pulses.
// Assumes a pull-up on the pad while the timer releases it.
`timescale 1ns/100ps
module center_aligned_pwm_load_model (
  // Clock
  input  logic        pclk,
  // Pad drive from the timer
  input  logic        drv,
  input  logic        drv_en,
  // Measured pad
  output logic        pad,
  output logic [15:0] high_len,
  output logic [15:0] period_len
);
  logic [15:0] cyc;
  logic [15:0] rise_at;
  logic        last;
  // Released pad goes to the pull-up level
  assign pad = drv_en ? drv : 1'b1;
  initial begin
    cyc = 16'h0000;
    rise_at = 16'h0000;
    last = 1'b0;
    high_len = 16'h0000;
    period_len = 16'h0000;
  end
  // High phase and rise-to-rise period, in pclk cycles
  always @(posedge pclk) begin
    cyc <= cyc + 16'h0001;
    last <= pad;
    if (pad && !last) begin
      period_len <= cyc - rise_at;
      rise_at <= cyc;
    end
    if (!pad && last) high_len <= cyc - rise_at;
  end
endmodule

/* File: tb/center_aligned_pwm_timer_tb.sv */
// Self-checking bench for the center-aligned PWM timer over APB.
// Assumes channel 0 at 0x20 and one counter tick per pclk (prescale 0).
`timescale 1ns/100ps
module center_aligned_pwm_timer_tb;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, ovf_irq, pin, rerr;
  logic [7:0]  paddr, rdat;
  logic [31:0] pwdata, prdata;
  logic [1:0]  cap_in, ch_out, ch_oe, ch_irq;
  logic [15:0] hi_len, per_len;
  int          bad_count, n_compared, n;

  center_aligned_pwm_timer u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cap_in(cap_in), .ch_out(ch_out), .ch_oe(ch_oe), .ovf_irq(ovf_irq), .ch_irq(ch_irq)
  );
  center_aligned_pwm_load_model u_load (
    .pclk(pclk), .drv(ch_out[0]), .drv_en(ch_oe[0]), .pad(pin), .high_len(hi_len), .period_len(per_len)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task close_out;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; called just after a rising edge, holds until pready
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the slave; only the bench timeout ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 8'h04, v[7:0]);
  endtask

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk({8'h00, rdat}, {8'h00, exp});
  endtask

  task t_reset;
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h20, 8'h00);
    chk({14'h0000, ch_oe}, 16'h0000);
    apb(1'b0, 8'hF0, 8'h00);
    chk({15'h0000, rerr}, 16'h0001);
    $display("test reset done");
  endtask

  // Counter stopped: second byte loads, control writes discard halves
  task t_buffer;
    wr(8'h10, 8'h08);
    rd_chk(8'h10, 8'h00);
    wr(8'h0C, 8'h00);
    rd_chk(8'h10, 8'h08);
    wr(8'h28, 8'h03);
    rd_chk(8'h28, 8'h00);
    wr(8'h24, 8'h00);
    rd_chk(8'h28, 8'h03);
    wr(8'h28, 8'h05);
    wr(8'h20, 8'h28);
    wr(8'h24, 8'h00);
    rd_chk(8'h28, 8'h03);
    wr(8'h10, 8'h09);
    wr(8'h00, 8'h00);
    wr(8'h0C, 8'h00);
    rd_chk(8'h10, 8'h08);
    wr16(8'h24, 16'h0003);
    $display("test buffer done");
  endtask

  task t_center_aligned_pwm;
    wr(8'h00, 8'h28);
    repeat (40) @(posedge pclk);
    chk(hi_len, 16'h0006);
    chk(per_len, 16'h0010);
    rd_chk(8'h20, 8'hA8);
    wr(8'h20, 8'h24);
    repeat (40) @(posedge pclk);
    chk(hi_len, 16'h000A);
    wr(8'h20, 8'h28);
    $display("test center_aligned_pwm done");
  endtask

  task t_extremes;
    logic [15:0] v [3];
    logic        lvl [3];
    int          bad;
    v = '{16'h0000, 16'h8003, 16'h0009};
    lvl = '{1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      wr16(8'h24, v[i]);
      repeat (40) @(posedge pclk);
      bad = 0;
      repeat (20) begin
        @(posedge pclk);
        if (pin !== lvl[i]) bad++;
      end
      chk(bad[15:0], 16'h0000);
    end
    wr16(8'h24, 16'h0003);
    repeat (40) @(posedge pclk);
    $display("test extremes done");
  endtask

  // Running counter: a new value waits for the step to the modulo
  task t_sync;
    wr(8'h24, 8'h00);
    for (n = 0; n < 40 && pin !== 1'b0; n++) @(posedge pclk);
    for (n = 0; n < 40 && pin !== 1'b1; n++) @(posedge pclk);
    chk({15'h0000, pin}, 16'h0001);
    wr(8'h28, 8'h05);
    rd_chk(8'h28, 8'h03);
    repeat (20) @(posedge pclk);
    rd_chk(8'h28, 8'h05);
    $display("test sync done");
  endtask

  task t_flags;
    wr(8'h00, 8'h68);
    repeat (20) @(posedge pclk);
    rd_chk(8'h00, 8'hE8);
    repeat (20) @(posedge pclk);
    wr(8'h00, 8'h68);
    chk({15'h0000, ovf_irq}, 16'h0001);
    wr(8'h00, 8'hA0);
    @(posedge pclk);  // Requests follow flag and enable one cycle late
    chk({15'h0000, ovf_irq}, 16'h0000);
    wr(8'h00, 8'hE0);
    @(posedge pclk);
    chk({15'h0000, ovf_irq}, 16'h0001);
    rd_chk(8'h00, 8'hE0);
    wr(8'h00, 8'h60);
    rd_chk(8'h00, 8'h60);
    chk({15'h0000, ovf_irq}, 16'h0000);
    wr(8'h20, 8'hE8);
    @(posedge pclk);
    chk({14'h0000, ch_irq}, 16'h0001);
    rd_chk(8'h20, 8'hE8);
    wr(8'h20, 8'h68);
    @(posedge pclk);
    chk({14'h0000, ch_irq}, 16'h0000);
    $display("test flags done");
  endtask

  // Channel 1: match flag from the up/down run, cleared, then set by a capture edge
  task t_capture;
    wr(8'h00, 8'h08);
    rd_chk(8'h30, 8'h80);
    wr(8'h30, 8'h04);
    rd_chk(8'h30, 8'h04);
    chk({14'h0000, ch_oe}, 16'h0001);
    cap_in[1] <= 1'b1;
    @(posedge pclk);
    rd_chk(8'h30, 8'h84);
    $display("test capture done");
  endtask

  // Hang guard, well above the roughly 600 cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    close_out;
  end

  initial begin
    bad_count = 0;
    n_compared = 0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    cap_in = 2'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_buffer;
    t_center_aligned_pwm;
    t_extremes;
    t_sync;
    t_flags;
    t_capture;
    close_out;
  end
endmodule
